/* rtl/lcal_pkg.sv */
// Purpose: Constants and types for the limit check and alert logic
// Assumes: 20 MHz system clock, 16-bit registers on an 8-bit address
// Notes: Offsets and bit positions shared by design and bench
package lcal_pkg;
  localparam int unsigned CLK_NS = 50;
  localparam int unsigned NUM_CH = 11;
  localparam int unsigned NUM_LIM = 14;
  localparam int unsigned REVISIT_NS = 18_000_000;
  localparam int unsigned SLOT_CYC = REVISIT_NS / (NUM_CH * CLK_NS);
  localparam int unsigned REPEAT_LSB_MS = 10_000;
  localparam int unsigned REPEAT_LSB_CYC =
    REPEAT_LSB_MS * (1_000_000 / CLK_NS);

  // Register addresses
  localparam logic [7:0] ADDR_CTL = 8'h00;
  localparam logic [7:0] ADDR_SHUNT = 8'h01;
  localparam logic [7:0] ADDR_CAPFB = 8'h02;
  localparam logic [7:0] ADDR_REPEAT = 8'h03;
  localparam logic [7:0] ADDR_MON_MASK = 8'h04;
  localparam logic [7:0] ADDR_MON_STATUS = 8'h05;
  localparam logic [7:0] ADDR_ALARM_MASK = 8'h06;
  localparam logic [7:0] ADDR_ALARM_CLEAR = 8'h07;
  localparam logic [7:0] ADDR_ALARM = 8'h08;
  localparam logic [7:0] ADDR_CELL_COUNT = 8'h09;
  localparam logic [7:0] ADDR_LIMIT_BASE = 8'h10;
  localparam logic [7:0] ADDR_MEAS_BASE = 8'h20;

  // Control register fields
  localparam int unsigned CTL_START = 0;
  localparam int unsigned CTL_AUX_BUF = 1;
  localparam int unsigned CTL_CAP_SCALE = 2;

  // Monitor status fields
  localparam int unsigned MON_CAP_RUN = 0;
  localparam int unsigned MON_ESR_RUN = 1;
  localparam int unsigned MON_CAP_DONE = 2;
  localparam int unsigned MON_ESR_DONE = 3;
  localparam int unsigned MON_CAP_FAIL = 4;
  localparam int unsigned MON_ESR_FAIL = 5;
  localparam int unsigned MON_WAIT = 6;
  localparam int unsigned MON_W = 7;

  // Alarm bits; even bits below-limit checks except noted
  localparam int unsigned AL_CELL_LOW = 0;
  localparam int unsigned AL_CELL_HIGH = 1;
  localparam int unsigned AL_AUX_LOW = 2;
  localparam int unsigned AL_AUX_HIGH = 3;
  localparam int unsigned AL_VIN_LOW = 4;
  localparam int unsigned AL_VIN_HIGH = 5;
  localparam int unsigned AL_STACK_LOW = 6;
  localparam int unsigned AL_STACK_HIGH = 7;
  localparam int unsigned AL_VOUT_LOW = 8;
  localparam int unsigned AL_VOUT_HIGH = 9;
  localparam int unsigned AL_IIN_HIGH = 10;
  localparam int unsigned AL_ICHG_LOW = 11;
  localparam int unsigned AL_TEMP_COLD = 12;
  localparam int unsigned AL_TEMP_HOT = 13;

  // Channel order of the converter scan
  localparam logic [3:0] CH_CELL4 = 4'h3;
  localparam logic [3:0] CH_AUX = 4'h4;
  localparam logic [3:0] CH_VIN = 4'h5;
  localparam logic [3:0] CH_STACK = 4'h6;
  localparam logic [3:0] CH_VOUT = 4'h7;
  localparam logic [3:0] CH_IIN = 4'h8;
  localparam logic [3:0] CH_ICHG = 4'h9;
  localparam logic [3:0] CH_TEMP = 4'ha;

  // Reset values
  localparam logic [15:0] SHUNT_RST = 16'h3999;
  localparam logic [15:0] CAPFB_RST = 16'h0000;

  // Alert response
  localparam logic [6:0] ARA_ADDR = 7'h0c;
  localparam logic [6:0] DEV_ADDR = 7'h09;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] data;
  } lcal_bus_req_t;
endpackage

/* rtl/lcal_alert_top.sv */
// Purpose: Limit checking, alarm latches, monitor events and alert line
// Assumes: scl/sda/straps/shunt flags asynchronous; adcData same clock
// Notes: Alert response handled by a sampled bus responder
//
// Operation
// R1 - Masked rising edge of a monitor status bit pulls alert low
// R2 - Capacitor monitor sets and clears its status bits during a test
// R3 - All limit checks and alarm enables off after reset
// R4 - Enabled limit beyond level sets alarm bit and pulls alert low
// R5 - One converter visits eleven channels, each about every 18 ms
// R6 - After answering alert response, release alert until new excess
// R7 - Writing one to alarm-clear bit resets that latched alarm
// R8 - Writing zero to alarm-enable bit disables it and clears alarm
// R9 - Alarm register returns every set and uncleared alarm
// R10 - Own levels per voltage; all cells share one pair
// R11 - Input current checked against high limit
// R12 - Charge current checked against low limit
// R13 - Die temperature checked against cold and hot levels
// R14 - Aux buffer enable bit routes aux input through buffer
// R15 - Aux input has low and high alarms with own enables
// R16 - Shunt level writable, resets to code for 2.7 V
// R17 - Feedback reference resets to 1.2 V code, host writable
// R18 - Cap/ESR test starts on request, repeats if period nonzero
// R19 - Cell count register reports straps, high strap upper bit
// R20 - Any active shunt lowers charging current; code does so only while shunt level is nonzero
// R21 - Converter runs freely, storing each channel's latest sample
// R22 - 16-bit registers on 8-bit addresses, word access only
// R23 - Answer alert address with own address, lowest wins
// R24 - Start bit self-clears at test start; period LSB is 10 s
// R25 - Shunt level zero disables all shunt regulators
// R26 - Open-drain alert held from event until arbitration won
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none
module lcal_alert_top #(
  parameter int unsigned SLOT_CYCLES = lcal_pkg::SLOT_CYC,
  parameter int unsigned REPEAT_CYCLES = lcal_pkg::REPEAT_LSB_CYC,
  parameter logic [15:0] CAPFB_INIT = lcal_pkg::CAPFB_RST
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire lcal_pkg::lcal_bus_req_t busReq,
  output logic [15:0] busRdata,
  input wire logic [15:0] adcData,
  output logic [3:0] adcChannel,
  input wire logic capPhaseDone,
  input wire logic capPhaseFail,
  input wire logic esrPhaseDone,
  input wire logic esrPhaseFail,
  output logic capTestRun,
  output logic esrTestRun,
  input wire logic cellCountStrapLow,
  input wire logic cellCountStrapHigh,
  input wire logic [3:0] shuntActive,
  output logic shuntEnable,
  output logic chargeReduce,
  output logic [15:0] shuntLevel,
  output logic [15:0] capFbLevel,
  output logic auxBufferEnable,
  output logic capScaleSmall,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic alertOut,
  output logic alertOe
);
  import lcal_pkg::*;

  typedef enum logic [1:0] {TS_IDLE, TS_CAP, TS_ESR} lcal_test_t;
  typedef enum logic [2:0] {
    AS_IDLE, AS_ADDR, AS_ACK, AS_SEND, AS_SKIP
  } lcal_ara_t;

  logic [2:0] ctl_reg;
  logic [15:0] shunt_reg, capFb_reg, repeat_reg;
  logic [MON_W-1:0] monMask_reg, mon_reg, monPrev_reg;
  logic [NUM_LIM-1:0] alarmMask_reg, alarm_reg, alarm_next;
  logic [15:0] limit_reg [NUM_LIM];
  logic [15:0] meas_reg [NUM_CH];
  logic [1:0] cellCount_reg;
  logic [3:0] chan_reg;
  logic [31:0] slot_reg, repTick_reg;
  logic [15:0] repCount_reg;
  logic sampleTick, testBegin, repeatDue;
  logic [NUM_LIM-1:0] exceed, newSet;
  logic [MON_W-1:0] monEvent;
  logic alert_reg, araWon;
  lcal_test_t test_reg;
  lcal_ara_t ara_reg;
  logic [1:0] sclSync, sdaSync, strapSync;
  logic [3:0] shuntMeta, shuntSync;
  logic sclPrev, sdaPrev, sclRise, sclFall, busStart, busStop;
  logic [7:0] shift_reg;
  logic [3:0] bitCnt_reg;
  logic araMatch_reg, sdaLow_reg;

  function automatic logic [3:0] limitChannel(input int unsigned b);
    unique case (b)
      AL_AUX_LOW, AL_AUX_HIGH: limitChannel = CH_AUX;
      AL_VIN_LOW, AL_VIN_HIGH: limitChannel = CH_VIN;
      AL_STACK_LOW, AL_STACK_HIGH: limitChannel = CH_STACK;
      AL_VOUT_LOW, AL_VOUT_HIGH: limitChannel = CH_VOUT;
      AL_IIN_HIGH: limitChannel = CH_IIN;
      AL_ICHG_LOW: limitChannel = CH_ICHG;
      AL_TEMP_COLD, AL_TEMP_HOT: limitChannel = CH_TEMP;
      default: limitChannel = 4'hf;
    endcase
  endfunction

  function automatic logic isWrite(input lcal_bus_req_t r,
                                   input logic [7:0] a);
    isWrite = r.wr && (r.addr == a);
  endfunction

  // Slot timer and channel scan
  assign sampleTick = (slot_reg == 32'(SLOT_CYCLES - 1));
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      slot_reg <= 32'h0;
      chan_reg <= 4'h0;
    end else if (sampleTick) begin
      slot_reg <= 32'h0;
      chan_reg <= (chan_reg == 4'(NUM_CH - 1)) ? 4'h0 : chan_reg + 4'h1; // R5
    end else begin
      slot_reg <= slot_reg + 32'h1;
    end
  end
  assign adcChannel = chan_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NUM_CH; i++) meas_reg[i] <= 16'h0;
    end else if (sampleTick) begin
      meas_reg[chan_reg] <= adcData; // R21
    end
  end

  // Limit comparison of the sample just stored
  always_comb begin
    exceed = '0;
    for (int b = 0; b < NUM_LIM; b++) begin
      logic hit, isHigh, onChan;
      hit = 1'b0;
      onChan = 1'b0;
      isHigh = (b[0] == 1'b1) ^ (b == AL_IIN_HIGH) ^ (b == AL_ICHG_LOW);
      if (b == AL_IIN_HIGH) isHigh = 1'b1; // R11
      if (b == AL_ICHG_LOW) isHigh = 1'b0; // R12
      if (b <= AL_CELL_HIGH) onChan = (chan_reg <= CH_CELL4); // R10
      else onChan = (chan_reg == limitChannel(b)); // R10 R13 R15
      if (isHigh) hit = $signed(adcData) > $signed(limit_reg[b]);
      else hit = $signed(adcData) < $signed(limit_reg[b]);
      exceed[b] = sampleTick && onChan && hit && alarmMask_reg[b]; // R4
    end
  end
  assign newSet = exceed & ~alarm_reg;

  // Alarm latches; a fresh excess wins over a clear
  always_comb begin
    alarm_next = alarm_reg;
    if (isWrite(busReq, ADDR_ALARM_CLEAR))
      alarm_next = alarm_next & ~busReq.data[NUM_LIM-1:0]; // R7
    if (isWrite(busReq, ADDR_ALARM_MASK))
      alarm_next = alarm_next & busReq.data[NUM_LIM-1:0]; // R8
    alarm_next = alarm_next | exceed; // R4
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) alarm_reg <= '0; // R3
    else alarm_reg <= alarm_next;
  end

  // Host-written configuration
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_reg <= 3'h0;
      shunt_reg <= SHUNT_RST; // R16
      capFb_reg <= CAPFB_INIT; // R17
      repeat_reg <= 16'h0;
      monMask_reg <= '0;
      alarmMask_reg <= '0; // R3
      for (int i = 0; i < NUM_LIM; i++) limit_reg[i] <= 16'h0;
    end else begin
      if (isWrite(busReq, ADDR_CTL)) ctl_reg <= busReq.data[2:0];
      else if (testBegin) ctl_reg[CTL_START] <= 1'b0; // R24
      if (isWrite(busReq, ADDR_SHUNT)) shunt_reg <= busReq.data; // R16
      if (isWrite(busReq, ADDR_CAPFB)) capFb_reg <= busReq.data; // R17
      if (isWrite(busReq, ADDR_REPEAT)) repeat_reg <= busReq.data;
      if (isWrite(busReq, ADDR_MON_MASK))
        monMask_reg <= busReq.data[MON_W-1:0];
      if (isWrite(busReq, ADDR_ALARM_MASK))
        alarmMask_reg <= busReq.data[NUM_LIM-1:0]; // R8
      for (int i = 0; i < NUM_LIM; i++)
        if (isWrite(busReq, ADDR_LIMIT_BASE + 8'(i)))
          limit_reg[i] <= busReq.data;
    end
  end

  // Read port, data valid the cycle after the strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busRdata <= 16'h0;
    end else if (busReq.rd) begin
      busRdata <= 16'h0;
      unique case (busReq.addr) // R22
        ADDR_CTL: busRdata <= {13'h0, ctl_reg};
        ADDR_SHUNT: busRdata <= shunt_reg;
        ADDR_CAPFB: busRdata <= capFb_reg;
        ADDR_REPEAT: busRdata <= repeat_reg;
        ADDR_MON_MASK: busRdata <= 16'(monMask_reg);
        ADDR_MON_STATUS: busRdata <= 16'(mon_reg);
        ADDR_ALARM_MASK: busRdata <= 16'(alarmMask_reg);
        ADDR_ALARM: busRdata <= 16'(alarm_reg); // R9
        ADDR_CELL_COUNT: busRdata <= {14'h0, cellCount_reg}; // R19
        default: begin
          for (int i = 0; i < NUM_LIM; i++)
            if (busReq.addr == ADDR_LIMIT_BASE + 8'(i))
              busRdata <= limit_reg[i];
          for (int i = 0; i < NUM_CH; i++)
            if (busReq.addr == ADDR_MEAS_BASE + 8'(i))
              busRdata <= meas_reg[i]; // R21
        end
      endcase
    end
  end

  // Capacitance and ESR test sequencing
  assign testBegin = (test_reg == TS_IDLE) &&
    (ctl_reg[CTL_START] || repeatDue); // R18
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      test_reg <= TS_IDLE;
      mon_reg <= '0;
    end else begin
      unique case (test_reg)
        TS_IDLE: if (testBegin) begin
          test_reg <= TS_CAP;
          mon_reg <= '0;
          mon_reg[MON_CAP_RUN] <= 1'b1; // R2
        end
        TS_CAP: if (capPhaseFail) begin
          test_reg <= TS_IDLE;
          mon_reg[MON_CAP_RUN] <= 1'b0;
          mon_reg[MON_CAP_FAIL] <= 1'b1; // R2
          mon_reg[MON_ESR_FAIL] <= 1'b1;
        end else if (capPhaseDone) begin
          test_reg <= TS_ESR;
          mon_reg[MON_CAP_RUN] <= 1'b0;
          mon_reg[MON_CAP_DONE] <= 1'b1; // R2
          mon_reg[MON_ESR_RUN] <= 1'b1;
        end
        TS_ESR: if (esrPhaseFail || esrPhaseDone) begin
          test_reg <= TS_IDLE;
          mon_reg[MON_ESR_RUN] <= 1'b0;
          mon_reg[MON_ESR_FAIL] <= esrPhaseFail; // R2
          mon_reg[MON_ESR_DONE] <= !esrPhaseFail;
        end
        default: test_reg <= TS_IDLE;
      endcase
      if (test_reg != TS_IDLE || testBegin) mon_reg[MON_WAIT] <= 1'b0;
      else mon_reg[MON_WAIT] <= (repeat_reg != 16'h0); // R18
    end
  end
  assign capTestRun = (test_reg == TS_CAP);
  assign esrTestRun = (test_reg == TS_ESR);

  // Repeat timer counts 10 s units after a test ends
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      repTick_reg <= 32'h0;
      repCount_reg <= 16'h0;
    end else if (test_reg != TS_IDLE || repeat_reg == 16'h0) begin
      repTick_reg <= 32'h0;
      repCount_reg <= 16'h0;
    end else if (repTick_reg == 32'(REPEAT_CYCLES - 1)) begin
      repTick_reg <= 32'h0;
      repCount_reg <= repCount_reg + 16'h1; // R24
    end else begin
      repTick_reg <= repTick_reg + 32'h1;
    end
  end
  assign repeatDue = (repeat_reg != 16'h0) && (repCount_reg >= repeat_reg);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) monPrev_reg <= '0;
    else monPrev_reg <= mon_reg;
  end
  assign monEvent = mon_reg & ~monPrev_reg & monMask_reg; // R1

  // Alert line: set on any event, released only on a won response
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) alert_reg <= 1'b0;
    else if ((|newSet) || (|monEvent)) alert_reg <= 1'b1; // R1 R4 R26
    else if (araWon) alert_reg <= 1'b0; // R6
  end
  assign alertOut = 1'b0;
  assign alertOe = alert_reg; // R26

  // Pin synchronisers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sclSync <= 2'b11;
      sdaSync <= 2'b11;
      strapSync <= 2'b00;
      shuntMeta <= 4'h0;
      shuntSync <= 4'h0;
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
      cellCount_reg <= 2'b00;
    end else begin
      sclSync <= {sclSync[0], sclIn};
      sdaSync <= {sdaSync[0], sdaIn};
      strapSync <= {cellCountStrapHigh, cellCountStrapLow};
      shuntMeta <= shuntActive;
      shuntSync <= shuntMeta;
      sclPrev <= sclSync[1];
      sdaPrev <= sdaSync[1];
      cellCount_reg <= strapSync; // R19
    end
  end
  assign sclRise = sclSync[1] && !sclPrev;
  assign sclFall = !sclSync[1] && sclPrev;
  assign busStart = sclSync[1] && sclPrev && sdaPrev && !sdaSync[1];
  assign busStop = sclSync[1] && sclPrev && !sdaPrev && sdaSync[1];

  // Alert response responder with bitwise arbitration
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ara_reg <= AS_IDLE;
      shift_reg <= 8'h0;
      bitCnt_reg <= 4'h0;
      araMatch_reg <= 1'b0;
      sdaLow_reg <= 1'b0;
      araWon <= 1'b0;
    end else begin
      araWon <= 1'b0;
      if (busStop) begin
        ara_reg <= AS_IDLE;
        sdaLow_reg <= 1'b0;
      end else if (busStart) begin
        ara_reg <= AS_ADDR;
        bitCnt_reg <= 4'h0;
        araMatch_reg <= 1'b0;
        sdaLow_reg <= 1'b0;
      end else begin
        unique case (ara_reg)
          AS_IDLE, AS_SKIP: sdaLow_reg <= 1'b0;
          AS_ADDR: begin
            if (sclRise) begin
              shift_reg <= {shift_reg[6:0], sdaSync[1]};
              bitCnt_reg <= bitCnt_reg + 4'h1;
              if (bitCnt_reg == 4'h7)
                araMatch_reg <= alert_reg &&
                  ({shift_reg[6:0], sdaSync[1]} == {ARA_ADDR, 1'b1}); // R23
            end else if (sclFall && bitCnt_reg == 4'h8) begin
              ara_reg <= araMatch_reg ? AS_ACK : AS_SKIP;
              sdaLow_reg <= araMatch_reg;
            end
          end
          AS_ACK: if (sclFall) begin
            ara_reg <= AS_SEND;
            bitCnt_reg <= 4'h0;
            sdaLow_reg <= !DEV_ADDR[6];
          end
          AS_SEND: begin
            if (sclRise) begin
              if (!sdaLow_reg && !sdaSync[1]) begin
                ara_reg <= AS_SKIP; // R23
                sdaLow_reg <= 1'b0;
              end else begin
                bitCnt_reg <= bitCnt_reg + 4'h1;
                araWon <= (bitCnt_reg == 4'h7); // R6 R23
              end
            end else if (sclFall) begin
              if (bitCnt_reg < 4'h7) sdaLow_reg <= !DEV_ADDR[3'(6 - bitCnt_reg)];
              else if (bitCnt_reg == 4'h7) sdaLow_reg <= 1'b1;
              else begin
                sdaLow_reg <= 1'b0;
                ara_reg <= AS_SKIP;
              end
            end
          end
          default: ara_reg <= AS_IDLE;
        endcase
      end
    end
  end
  assign sdaOut = 1'b0;
  assign sdaOe = sdaLow_reg;

  // Analog control outputs
  assign shuntEnable = (shunt_reg != 16'h0); // R25
  assign chargeReduce = shuntEnable && (|shuntSync); // R20
  assign shuntLevel = shunt_reg;
  assign capFbLevel = capFb_reg;
  assign auxBufferEnable = ctl_reg[CTL_AUX_BUF]; // R14
  assign capScaleSmall = ctl_reg[CTL_CAP_SCALE];

  AST_NO_ALARM_UNMASKED: assert property (@(posedge clk) disable iff (!arst_n)
    (alarmMask_reg == '0) |=> (alarm_reg & ~$past(alarm_reg)) == '0) // R3
    else $error("alarm set while all enables off");
  AST_ALARM_LATCH: assert property (@(posedge clk) disable iff (!arst_n)
    (|newSet) |=> ((alarm_reg & $past(newSet)) == $past(newSet))
      && alertOe) // R4
    else $error("excess did not latch alarm and alert");
  AST_MON_ALERT: assert property (@(posedge clk) disable iff (!arst_n)
    (|monEvent) |=> alertOe) // R1
    else $error("masked monitor edge did not alert");
  AST_RELEASE: assert property (@(posedge clk) disable iff (!arst_n)
    (araWon && !(|newSet) && !(|monEvent)) |=> !alertOe) // R6
    else $error("alert not released after response");
  AST_CLEAR: assert property (@(posedge clk) disable iff (!arst_n)
    (isWrite(busReq, ADDR_ALARM_CLEAR) && exceed == '0)
      |=> (alarm_reg & $past(busReq.data[NUM_LIM-1:0])) == '0) // R7
    else $error("alarm clear ignored");
  AST_MASK_CLEAR: assert property (@(posedge clk) disable iff (!arst_n)
    isWrite(busReq, ADDR_ALARM_MASK)
      |=> (alarm_reg & ~alarmMask_reg & ~$past(exceed)) == '0) // R8
    else $error("disabled alarm still set");
  AST_READ_ALARM: assert property (@(posedge clk) disable iff (!arst_n)
    (busReq.rd && busReq.addr == ADDR_ALARM)
      |=> busRdata == 16'($past(alarm_reg))) // R9
    else $error("alarm read mismatch");
  AST_START_CLEARS: assert property (@(posedge clk) disable iff (!arst_n)
    (testBegin && !busReq.wr) |=> !ctl_reg[CTL_START] && capTestRun) // R24
    else $error("start bit not cleared at test start");
  AST_SCAN: assert property (@(posedge clk) disable iff (!arst_n)
    sampleTick |=> meas_reg[$past(chan_reg)] == $past(adcData)
      && chan_reg != $past(chan_reg)) // R5
    else $error("scan did not store and advance");
endmodule // lcal_alert_top
`default_nettype wire

/* test/lcal_smbus_host.sv */
// Purpose: Host side of the alert response read over SMBus
// Assumes: only this host drives SCL; SDA has a pull-up
// Notes: SCL stands high between frames, 400 ns period inside
`timescale 1ns/100ps
`default_nettype none
module lcal_smbus_host (
  output logic scl,
  output logic sdaLow,
  input wire logic sdaLine
);
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end

  // Data set while SCL low, sampled mid-way through the high phase
  task automatic clk_bit(input logic b, output logic s);
    sdaLow = ~b;
    #200 scl = 1'b1;
    #100 s = sdaLine;
    #100 scl = 1'b0;
  endtask

  task automatic ara(output logic ack, output logic [7:0] rx);
    logic s;
    logic [7:0] req;
    req = {lcal_pkg::ARA_ADDR, 1'b1};
    #37 sdaLow = 1'b1;
    #200 scl = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(req[i], s);
    end
    clk_bit(1'b1, s);
    ack = ~s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, s);
      rx[i] = s;
    end
    clk_bit(1'b1, s);
    sdaLow = 1'b1;
    #200 scl = 1'b1;
    #200 sdaLow = 1'b0;
    #200;
  endtask
endmodule // lcal_smbus_host
`default_nettype wire

/* test/testbench.sv */
// Purpose: Self-checking bench for the limit check and alert logic
// Assumes: straps static, fail inputs pulsed by the test, host model on SMBus
// Notes: short slot and repeat counts keep the run brief
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import lcal_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  lcal_bus_req_t busReq = '0;
  logic [15:0] busRdata, shuntLevel, capFbLevel;
  logic [15:0] adcData = '0;
  logic [3:0] adcChannel;
  logic [3:0] shuntActive = 4'h4;
  logic capDone = 1'b0, esrDone = 1'b0, lo, ack;
  logic capFail = 1'b0, esrFail = 1'b0;
  logic capTestRun, esrTestRun, shuntEnable, chargeReduce;
  logic auxBufferEnable, scl, sdaLow, sdaOe, alertOe;
  logic [7:0] rx;
  logic [15:0] meas [11];
  int errors = 0, checked = 0, cycles = 0;
  wire sdaLine;
  assign sdaLine = ~(sdaLow | sdaOe);

  always #25 clk = ~clk;
  always @(posedge clk) adcData <= meas[adcChannel];

  lcal_alert_top #(.SLOT_CYCLES(8), .REPEAT_CYCLES(20)) dut (
    .clk(clk), .arst_n(arst_n), .busReq(busReq), .busRdata(busRdata),
    .adcData(adcData), .adcChannel(adcChannel),
    .capPhaseDone(capDone), .capPhaseFail(capFail),
    .esrPhaseDone(esrDone), .esrPhaseFail(esrFail),
    .capTestRun(capTestRun), .esrTestRun(esrTestRun),
    .cellCountStrapLow(1'b0), .cellCountStrapHigh(1'b1),
    .shuntActive(shuntActive), .shuntEnable(shuntEnable),
    .chargeReduce(chargeReduce), .shuntLevel(shuntLevel),
    .capFbLevel(capFbLevel), .auxBufferEnable(auxBufferEnable),
    .capScaleSmall(), .sclIn(scl), .sdaIn(sdaLine), .sdaOut(),
    .sdaOe(sdaOe), .alertOut(), .alertOe(alertOe));

  lcal_smbus_host host (.scl(scl), .sdaLow(sdaLow), .sdaLine(sdaLine));

  task automatic finish_test;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      finish_test();
    end
  end

  task automatic chk(input string n, input logic [15:0] s,
                     input logic [15:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk) busReq <= '{1'b1, 1'b0, a, d};
    @(posedge clk) busReq <= '0;
    #1;
  endtask

  task automatic rchk(input string n, input logic [7:0] a,
                      input logic [15:0] e);
    @(posedge clk) busReq <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge clk) busReq <= '0;
    @(posedge clk);
    chk(n, busRdata, e);
  endtask

  // Bounded wait: 0 alert, 1 capacitance run, 2 ESR run
  task automatic wait_on(input int w, input int lim);
    for (int k = 0; k < lim; k++) begin
      if ((w == 0 ? alertOe : w == 1 ? capTestRun : esrTestRun) === 1'b1)
        break;
      @(posedge clk) #1;
    end
    #1;
  endtask

  task automatic pulse(input int w);
    @(posedge clk) begin
      capDone <= (w == 0);
      esrDone <= (w == 1);
      capFail <= (w == 2);
      esrFail <= (w == 3);
    end
    @(posedge clk) begin
      capDone <= 1'b0;
      esrDone <= 1'b0;
      capFail <= 1'b0;
      esrFail <= 1'b0;
    end
    #1;
  endtask

  task automatic do_ara(input logic [7:0] e, input logic eAck);
    host.ara(ack, rx);
    chk("ara ack", {15'h0, ack}, {15'h0, eAck});
    chk("ara data", {8'h0, rx}, {8'h0, e});
    repeat (4) @(posedge clk);
    #1;
    chk("alert released", {15'h0, alertOe}, 16'h0000);
  endtask

  initial begin
    for (int c = 0; c < 11; c++) meas[c] = 16'h0100 + 16'(c);
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rchk("shunt", ADDR_SHUNT, SHUNT_RST);
    rchk("capfb", ADDR_CAPFB, CAPFB_RST);
    rchk("alarm mask", ADDR_ALARM_MASK, 16'h0000);
    rchk("cell count", ADDR_CELL_COUNT, 16'h0002);
    rchk("unmapped", 8'hff, 16'h0000);
    chk("reduce", {15'h0, chargeReduce}, 16'h0001);
    wr(ADDR_CAPFB, 16'h0abc);
    chk("capfb out", capFbLevel, 16'h0abc);
    rchk("capfb", ADDR_CAPFB, 16'h0abc);
    wr(ADDR_SHUNT, 16'h0000);
    chk("shunt on", {15'h0, shuntEnable}, 16'h0000);
    chk("reduce", {15'h0, chargeReduce}, 16'h0000);
    wr(ADDR_SHUNT, 16'h1234);
    chk("shunt out", shuntLevel, 16'h1234);
    rchk("shunt", ADDR_SHUNT, 16'h1234);
    wr(ADDR_CTL, 16'h0002);
    chk("aux buffer", {15'h0, auxBufferEnable}, 16'h0001);
    wr(ADDR_CTL, 16'h0000);
    chk("aux buffer", {15'h0, auxBufferEnable}, 16'h0000);
    wr(ADDR_ALARM, 16'hffff);
    rchk("alarm ro", ADDR_ALARM, 16'h0000);
    repeat (200) @(posedge clk);
    for (int c = 0; c < 11; c++)
      rchk("meas", ADDR_MEAS_BASE + 8'(c), 16'h0100 + 16'(c));
    chk("no alert", {15'h0, alertOe}, 16'h0000);
    // Each limit: trip it, latch, clear by either path, then answer
    for (int i = 0; i < 14; i++) begin
      lo = (i < 10) ? (i % 2 == 0) : (i == 11 || i == 12);
      wr(ADDR_LIMIT_BASE + 8'(i), lo ? 16'h0200 : 16'h0080);
      wr(ADDR_ALARM_MASK, 16'h0001 << i);
      wait_on(0, 200);
      rchk("alarm", ADDR_ALARM, 16'h0001 << i);
      wr(ADDR_LIMIT_BASE + 8'(i), lo ? 16'h0000 : 16'h7fff);
      if (i % 2 == 1) wr(ADDR_ALARM_MASK, 16'h0000);
      else wr(ADDR_ALARM_CLEAR, 16'h0001 << i);
      repeat (100) @(posedge clk);
      rchk("cleared", ADDR_ALARM, 16'h0000);
      chk("alert held", {15'h0, alertOe}, 16'h0001);
      do_ara({DEV_ADDR, 1'b0}, 1'b1);
    end
    do_ara(8'hff, 1'b0);
    wr(ADDR_MON_MASK, 16'h0001 << MON_CAP_DONE);
    wr(ADDR_CTL, 16'h0001);
    wait_on(1, 50);
    chk("cap run", {15'h0, capTestRun}, 16'h0001);
    rchk("start", ADDR_CTL, 16'h0000);
    rchk("status", ADDR_MON_STATUS, 16'h0001);
    chk("unmasked", {15'h0, alertOe}, 16'h0000);
    pulse(0);
    wait_on(2, 50);
    chk("esr run", {15'h0, esrTestRun}, 16'h0001);
    wait_on(0, 10);
    chk("mon alert", {15'h0, alertOe}, 16'h0001);
    pulse(1);
    rchk("status", ADDR_MON_STATUS, 16'h000c);
    do_ara({DEV_ADDR, 1'b0}, 1'b1);
    wr(ADDR_REPEAT, 16'h0001);
    wr(ADDR_CTL, 16'h0001);
    wait_on(1, 50);
    pulse(0);
    wait_on(2, 50);
    pulse(1);
    repeat (2) @(posedge clk);
    #1;
    chk("idle", {15'h0, capTestRun}, 16'h0000);
    wait_on(1, 60);
    chk("repeat", {15'h0, capTestRun}, 16'h0001);
    // Failed capacitance phase fails both, then a failed ESR phase
    pulse(2);
    rchk("cap fail", ADDR_MON_STATUS, 16'h0070);
    wait_on(1, 60);
    pulse(0);
    wait_on(2, 50);
    pulse(3);
    rchk("esr fail", ADDR_MON_STATUS, 16'h0064);
    finish_test();
  end
endmodule // testbench
`default_nettype wire
